// ==== shared/fcpe_pkg.sv ====
// Shared constants and types of the flash command sequencer (host side).
// Assumes a byte-mode parallel flash and a 125 MHz single-clock system.
package fcpe_pkg;
   // ----------------------------------------
   // Clock and bus timing
   // ----------------------------------------
   localparam int CLK_NS = 8;
   localparam int T_WP_NS = 35;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_ACC_NS = 70;
   localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_WIN_US = 50;
   localparam int WIN_CYC = T_WIN_US * 1000 / CLK_NS;
   localparam int T_SUSP_US = 15;
   localparam int SUSP_CYC = T_SUSP_US * 1000 / CLK_NS;
   localparam int T_POLL_MAX_S = 30;
   localparam longint POLL_CYC_L = longint'(T_POLL_MAX_S) * 64'd1000000000 / CLK_NS;
   localparam logic [31:0] POLL_CYC = POLL_CYC_L[31:0];
   localparam logic [31:0] WIN_MARGIN_CYC = 32'h0000_0040;

   // ----------------------------------------
   // Command addresses and codes (byte mode)
   // ----------------------------------------
   localparam logic [19:0] ADR_UNLK1 = 20'h00AAA;
   localparam logic [19:0] ADR_UNLK2 = 20'h00555;
   localparam logic [19:0] ADR_ANY = 20'h00000;
   localparam logic [7:0] CD_UNLK1 = 8'hAA;
   localparam logic [7:0] CD_UNLK2 = 8'h55;
   localparam logic [7:0] CD_RESET = 8'hF0;
   localparam logic [7:0] CD_AUTOSEL = 8'h90;
   localparam logic [7:0] CD_PROG = 8'hA0;
   localparam logic [7:0] CD_ERASE = 8'h80;
   localparam logic [7:0] CD_CHIP = 8'h10;
   localparam logic [7:0] CD_BLOCK = 8'h30;
   localparam logic [7:0] CD_SUSP = 8'hB0;
   localparam logic [7:0] CD_RESUME = 8'h30;

   // ----------------------------------------
   // Status word bit positions
   // ----------------------------------------
   localparam int ALT_BUSY_POS = 6;
   localparam int FAIL_POS = 5;

   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_RESET = 4'h1, OP_AUTOSEL = 4'h2, OP_PROGRAM = 4'h3,
      OP_CHIP = 4'h4, OP_BLOCK = 4'h5, OP_ADDBLK = 4'h6, OP_SUSPEND = 4'h7,
      OP_RESUME = 4'h8
   } fcpe_op_t;
endpackage

// ==== tb/fcpe_flash_model.sv ====
// Behavioural byte-mode flash: 4 blocks of 16 bytes, top block protected.
// Assumes writes latch on the rising write strobe; durations are short counts.
`timescale 1ns/1ps
module fcpe_flash_model #(
   parameter int PROG_CYC = 40,
   parameter int ERA_CYC = 80,
   parameter int WIN_CYC = 200,
   parameter logic [7:0] MAKER_ID = 8'h3C // Arbitrary value
) (
   // Clock
   input wire logic mclk,
   // Flash pins
   input wire logic [18:0] fl_addr,
   input wire logic fl_lsb,
   input wire logic [7:0] fl_dq_o,
   input wire logic fl_ce_n,
   input wire logic fl_oe_n,
   input wire logic fl_we_n,
   output logic [7:0] fl_dq_i,
   output logic ready_busy_out
);
   logic [7:0] mem [64];
   logic [7:0] d, st, last = 8'h00;
   logic [11:0] a;
   logic [3:0] sel = 4'h0;
   logic p7 = 0, tog = 0, err = 0, auto = 0, susp = 0, ers = 0, we_q = 1, busy;
   int pcnt = 0, cnt = 0, win = 0, step = 0;
   initial foreach (mem[i]) mem[i] = 8'hFF;
   // low bits only, shared pin is lowest address
   assign a = {fl_addr[10:0], fl_lsb};
   assign d = fl_dq_o;
   assign busy = pcnt > 0 || (!susp && (cnt > 0 || win > 0));
   assign ready_busy_out = ~busy;
   assign st = {pcnt > 0 ? p7 : susp, tog, err, 1'b0, win == 0, tog & sel[a[5:4]], 2'b00};
   // status in place of data; released bus inverts
   assign fl_dq_i = (fl_ce_n | fl_oe_n) ? ~last :
      (busy || err || (susp && sel[a[5:4]])) ? st : auto ? MAKER_ID : mem[a[5:0]];
   always @(negedge mclk) if (!fl_ce_n && !fl_oe_n) last <= fl_dq_i;
   // alternate on every read while active
   always @(negedge fl_oe_n) if (busy || err) tog <= ~tog;
   // durations and window as cycle counters
   always @(posedge mclk) begin
      we_q <= fl_we_n;
      if (pcnt > 0) pcnt <= pcnt - 1;
      if (!susp && win > 1) win <= win - 1;
      if (!susp && win == 1) begin win <= 0; cnt <= ERA_CYC; end
      if (!susp && cnt > 0) cnt <= cnt - 1;
      // only unprotected selected blocks set to one
      if (!susp && cnt == 1) begin
         for (int i = 0; i < 48; i++) if (sel[i / 16]) mem[i] <= 8'hFF;
         sel <= 4'h0;
      end
      if (fl_we_n && !we_q && !fl_ce_n && pcnt == 0) begin
         if (ers && !susp && (win > 0 || cnt > 0) && d == 8'hB0) susp <= 1;
         else if (susp && step == 0 && d == 8'h30) begin
            susp <= 0;
            if (win > 0) begin win <= 0; cnt <= ERA_CYC; end
         end
         else if (!susp && (cnt > 0 || (win > 0 && d != 8'h30))) begin end
         else if (!susp && win > 0) begin sel[a[5:4]] <= 1; win <= WIN_CYC; end
         else if (d == 8'hF0) begin err <= 0; auto <= 0; step <= 0; end
         else begin
            step <= 0;
            case (step)
               0, 4: if (a == 12'hAAA && d == 8'hAA) step <= step + 1;
               1, 5: if (a == 12'h555 && d == 8'h55) step <= step + 1;
               2: if (a == 12'hAAA) begin
                  if (d == 8'h90) auto <= 1;
                  if (d == 8'hA0) step <= 3;
                  if (d == 8'h80) step <= 4;
               end
               // protected target dropped, no zero to one
               3: if (a[5:4] != 2'b11) begin
                  err <= |(d & ~mem[a[5:0]]);
                  mem[a[5:0]] <= mem[a[5:0]] & d;
                  p7 <= ~d[7];
                  pcnt <= PROG_CYC;
               end
               6: if (a == 12'hAAA && d == 8'h10) begin
                  sel <= 4'hF; cnt <= ERA_CYC; ers <= 0;
               end else if (d == 8'h30) begin
                  sel[a[5:4]] <= 1; win <= WIN_CYC; ers <= 1;
               end
               default: step <= 0;
            endcase
         end
      end
   end
endmodule // fcpe_flash_model

// ==== tb/test_fcpe_ctrl.sv ====
// Self-checking bench of the flash command sequencer.
// Assumes the behavioural flash model with shortened durations.
`timescale 1ns/1ps
module test_fcpe_ctrl;
   import fcpe_pkg::*;
   typedef struct {fcpe_op_t op; logic [19:0] a; logic [7:0] d; logic e; logic [8:0] rd;} fcpe_row_t;
   localparam logic [7:0] ID = 8'h3C;
   logic mclk = 0, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_err, erase_suspended;
   logic [19:0] cmd_addr;
   logic [18:0] fl_addr;
   logic [7:0] cmd_data, rsp_data, dq_o, dq_i;
   logic pin_o, pin_oe, dq_oe, ce_n, oe_n, we_n, byte_n, ready_busy_out;
   fcpe_op_t cmd_op;
   fcpe_row_t rows [14];
   int failures = 0, comparisons = 0, cyc = 0, t;
   always #4 mclk = ~mclk;
   fcpe_ctrl #(.WIN_LEN(32'h0000_00C8), .POLL_LEN(32'h0000_07D0)) i_fcpe_ctrl (
      .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data),
      .erase_suspended(erase_suspended), .fl_addr(fl_addr),
      .shared_top_data_low_addr_pin_o(pin_o), .shared_top_data_low_addr_pin_oe(pin_oe),
      .shared_top_data_low_addr_pin_i(pin_oe ? pin_o : 1'b1), .fl_dq_o(dq_o),
      .fl_dq_oe(dq_oe), .fl_dq_i(dq_i), .fl_ce_n(ce_n), .fl_oe_n(oe_n), .fl_we_n(we_n),
      .fl_byte_n(byte_n), .ready_busy_out(ready_busy_out));
   fcpe_flash_model #(.MAKER_ID(ID)) i_fcpe_flash_model (
      .mclk(mclk), .fl_addr(fl_addr), .fl_lsb(pin_o), .fl_dq_o(dq_o), .fl_ce_n(ce_n),
      .fl_oe_n(oe_n), .fl_we_n(we_n), .fl_dq_i(dq_i), .ready_busy_out(ready_busy_out));
   task automatic print_verdict();
      $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk_bit(input logic g, input logic e);
      comparisons++;
      if (g !== e) begin failures++; $display("MISMATCH at %0t: bit %b exp %b", $time, g, e); end
   endtask
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin failures++; $display("MISMATCH at %0t: %h exp %h", $time, g, e); end
   endtask
   task automatic send(input fcpe_op_t op, input logic [19:0] a, input logic [7:0] d);
      int n;
      n = 0;
      // Let an edge pass so cmd_valid never falls and rises in one time step
      @(posedge mclk);
      #1;
      cmd_op = op; cmd_addr = a; cmd_data = d; cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1 && n < 4000) begin @(posedge mclk); #1; n++; end
      if (n >= 4000) begin failures++; $display("MISMATCH at %0t: no ready", $time); end
      @(posedge mclk); #1;
      cmd_valid = 1'b0;
   endtask
   task automatic run(input fcpe_op_t op, input logic [19:0] a, input logic [7:0] d,
                      input logic e, input logic [8:0] rd);
      int n;
      n = 0;
      send(op, a, d);
      while (rsp_valid !== 1'b1 && n < 4000) begin @(posedge mclk); #1; n++; end
      if (n >= 4000) begin failures++; $display("MISMATCH at %0t: no answer", $time); end
      chk_bit(rsp_err, e);
      if (rd[8]) chk_byte(rsp_data, rd[7:0]);
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         $display("MISMATCH at %0t: timeout", $time);
         print_verdict();
      end
   end
   initial begin
      rows = '{'{OP_RESET, 20'h0, 8'h00, 0, 9'h000}, '{OP_PROGRAM, 20'h4, 8'h5A, 0, 9'h000},
         '{OP_READ, 20'h4, 8'h00, 0, 9'h15A}, '{OP_PROGRAM, 20'h4, 8'hA5, 1, 9'h000},
         '{OP_READ, 20'h4, 8'h00, 0, 9'h100}, '{OP_PROGRAM, 20'h34, 8'h00, 0, 9'h000},
         '{OP_READ, 20'h34, 8'h00, 0, 9'h1FF}, '{OP_CHIP, 20'h0, 8'h00, 0, 9'h000},
         '{OP_READ, 20'h4, 8'h00, 0, 9'h1FF}, '{OP_PROGRAM, 20'h2, 8'h00, 0, 9'h000},
         '{OP_AUTOSEL, 20'h0, 8'h00, 0, 9'h000}, '{OP_READ, 20'h0, 8'h00, 0, {1'b1, ID}},
         '{OP_RESET, 20'h0, 8'h00, 0, 9'h000}, '{OP_RESUME, 20'h0, 8'h00, 1, 9'h000}};
      cmd_valid = 0; cmd_op = OP_READ; cmd_addr = 0; cmd_data = 0; rst_n = 0;
      repeat (16) @(posedge mclk);
      #1 rst_n = 1;
      repeat (3) @(posedge mclk);
      #1;
      foreach (rows[i]) begin
         run(rows[i].op, rows[i].a, rows[i].d, rows[i].e, rows[i].rd);
         $display("Row %0d done", i);
      end
      // Added block, window expiry and a protected block in the list
      run(OP_PROGRAM, 20'h12, 8'h00, 1'b0, 9'h000);
      send(OP_BLOCK, 20'h10, 8'h00);
      run(OP_ADDBLK, 20'h34, 8'h00, 1'b0, 9'h000);
      run(OP_READ, 20'h12, 8'h00, 1'b0, 9'h1FF);
      run(OP_READ, 20'h34, 8'h00, 1'b0, 9'h1FF);
      $display("Block test done");
      send(OP_BLOCK, 20'h0, 8'h00);
      send(OP_SUSPEND, 20'h0, 8'h00);
      t = 0;
      while (erase_suspended !== 1'b1 && t < 3000) begin @(posedge mclk); #1; t++; end
      chk_bit(erase_suspended, 1'b1);
      run(OP_PROGRAM, 20'h24, 8'h3C, 1'b0, 9'h000);
      run(OP_READ, 20'h24, 8'h00, 1'b0, 9'h13C);
      run(OP_RESUME, 20'h0, 8'h00, 1'b0, 9'h000);
      chk_bit(erase_suspended, 1'b0);
      run(OP_READ, 20'h2, 8'h00, 1'b0, 9'h1FF);
      $display("Suspend test done");
      rst_n = 0;
      #1;
      chk_bit(cmd_ready, 1'b1);
      chk_bit(we_n, 1'b1);
      chk_bit(dq_oe, 1'b0);
      chk_bit(pin_oe, 1'b0);
      chk_bit(byte_n, 1'b0);
      repeat (2) @(posedge mclk);
      #1 rst_n = 1;
      repeat (3) @(posedge mclk);
      #1;
      chk_bit(pin_oe, 1'b1);
      run(OP_READ, 20'h24, 8'h00, 1'b0, 9'h13C);
      $display("Reset test done");
      print_verdict();
   end
endmodule // test_fcpe_ctrl

// ==== verilog/fcpe_bus_cycle.sv ====
// One asynchronous flash bus cycle (write or read) timed in mclk cycles.
// Assumes start is only raised while the previous cycle has returned done.
`timescale 1ns/1ps
module fcpe_bus_cycle (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Request
   input wire logic start,
   input wire logic wr,
   input wire logic [19:0] addr,
   input wire logic [7:0] wdata,
   output logic done,
   output logic [7:0] rdata,
   // Flash pins
   output logic [18:0] fl_addr,
   output logic fl_lsb,
   output logic [7:0] fl_dq_o,
   output logic fl_dq_oe,
   input wire logic [7:0] fl_dq_i,
   output logic fl_ce_n,
   output logic fl_oe_n,
   output logic fl_we_n
);
   import fcpe_pkg::*;

   typedef enum logic [3:0] {
      PH_IDLE = 4'h1, PH_SETUP = 4'h2, PH_STROBE = 4'h4, PH_HOLD = 4'h8
   } fcpe_ph_t;

   typedef struct packed {
      fcpe_ph_t ph;
      logic wr;
      logic [3:0] cnt;
      logic done;
      logic [7:0] rdata;
      logic [19:0] addr;
      logic [7:0] dq;
      logic dq_oe;
      logic ce_n;
      logic oe_n;
      logic we_n;
   } fcpe_bus_t;

   fcpe_bus_t r_ff, nxt_r;

   always_comb begin
      nxt_r = r_ff;
      nxt_r.done = 1'b0;
      case (r_ff.ph)
         PH_IDLE: begin
            if (start) begin
               nxt_r.ph = PH_SETUP;
               nxt_r.wr = wr;
               nxt_r.addr = addr;
               nxt_r.dq = wdata;
               nxt_r.dq_oe = wr;
               nxt_r.ce_n = 1'b0;
            end
         end
         PH_SETUP: begin
            nxt_r.ph = PH_STROBE;
            nxt_r.cnt = r_ff.wr ? 4'(WP_CYC) : 4'(ACC_CYC);
            nxt_r.we_n = !r_ff.wr;
            nxt_r.oe_n = r_ff.wr;
         end
         PH_STROBE: begin
            if (r_ff.cnt > 4'h1) begin
               nxt_r.cnt = r_ff.cnt - 4'h1;
            end else begin
               // Data latched by the flash on the rising edge of write enable
               nxt_r.ph = PH_HOLD;
               nxt_r.we_n = 1'b1;
               nxt_r.oe_n = 1'b1;
               nxt_r.rdata = fl_dq_i;
            end
         end
         PH_HOLD: begin
            // Data held one cycle past the strobe for the hold time
            nxt_r.ph = PH_IDLE;
            nxt_r.ce_n = 1'b1;
            nxt_r.dq_oe = 1'b0;
            nxt_r.done = 1'b1;
         end
         default: nxt_r.ph = PH_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r_ff <= '{ph: PH_IDLE, wr: 1'b0, cnt: 4'h0, done: 1'b0, rdata: 8'h00,
                   addr: 20'h00000, dq: 8'h00, dq_oe: 1'b0, ce_n: 1'b1,
                   oe_n: 1'b1, we_n: 1'b1};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign done = r_ff.done;
   assign rdata = r_ff.rdata;
   assign fl_addr = r_ff.addr[19:1];
   assign fl_lsb = r_ff.addr[0];
   assign fl_dq_o = r_ff.dq;
   assign fl_dq_oe = r_ff.dq_oe;
   assign fl_ce_n = r_ff.ce_n;
   assign fl_oe_n = r_ff.oe_n;
   assign fl_we_n = r_ff.we_n;

   a_strobe_excl: assert property (@(posedge mclk) disable iff (!rst_n)
      !(!r_ff.we_n && !r_ff.oe_n)) else $error("write and output enables low together");
   a_dq_turnaround: assert property (@(posedge mclk) disable iff (!rst_n)
      r_ff.dq_oe |-> r_ff.oe_n) else $error("data driven while flash outputs enabled");
endmodule // fcpe_bus_cycle

// ==== verilog/fcpe_ctrl.sv ====
// Host-side command sequencer for a byte-mode parallel flash.
// Assumes the flash is strapped to byte mode by fl_byte_n and that the
// user holds cmd_valid until cmd_ready is seen high.
`timescale 1ns/1ps
// Functional notes
// - Multi-write commands start with two unlocks
// - Read/reset is one F0 write
// - Identification is unlock then 90 at AAA
// - Program is unlock, A0, address with data
// - Failure needs read/reset to clear
// - Chip erase is six writes ending 10
// - Block erase ends 30, repeated per block
// - Add blocks within fifty microsecond window
// - Suspend is B0, resume is 30
module fcpe_ctrl #(
   parameter logic [31:0] WIN_LEN = 32'(fcpe_pkg::WIN_CYC),
   parameter logic [31:0] POLL_LEN = fcpe_pkg::POLL_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // User command port
   input wire logic cmd_valid,
   input wire fcpe_pkg::fcpe_op_t cmd_op,
   input wire logic [19:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   output logic cmd_ready,
   // User answer port
   output logic rsp_valid,
   output logic rsp_err,
   output logic [7:0] rsp_data,
   output logic erase_suspended,
   // Flash pins
   output logic [18:0] fl_addr,
   output logic shared_top_data_low_addr_pin_o,
   output logic shared_top_data_low_addr_pin_oe,
   input wire logic shared_top_data_low_addr_pin_i,
   output logic [7:0] fl_dq_o,
   output logic fl_dq_oe,
   input wire logic [7:0] fl_dq_i,
   output logic fl_ce_n,
   output logic fl_oe_n,
   output logic fl_we_n,
   output logic fl_byte_n,
   input wire logic ready_busy_out
);
   import fcpe_pkg::*;

   // ----------------------------------------
   // Reset release and state
   // ----------------------------------------
   logic [1:0] rst_sync_ff;
   logic rst_s;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_s = rst_sync_ff[1];

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, ST_WR = 5'h02, ST_RD = 5'h04, ST_WIN = 5'h08, ST_POLL = 5'h10
   } fcpe_st_t;

   typedef struct packed {
      fcpe_st_t st;
      fcpe_op_t op;
      logic [19:0] addr;
      logic [7:0] data;
      logic [2:0] idx;
      logic rdy;
      logic rsp_v;
      logic rsp_e;
      logic [7:0] rsp_d;
      logic susp;
      logic err;
      logic prev_v;
      logic prev6;
      logic echk;
      logic [31:0] cnt;
      logic bstart;
      logic bwr;
      logic [19:0] baddr;
      logic [7:0] bdat;
      logic byte_n;
   } fcpe_ctl_t;

   fcpe_ctl_t r_ff, nxt_r;
   logic bdone;
   logic [7:0] brd;
   logic [27:0] w0;

   // ----------------------------------------
   // Command word tables
   // ----------------------------------------
   function automatic logic [2:0] seq_len(input fcpe_op_t op);
      case (op)
         OP_AUTOSEL: seq_len = 3'h3;
         OP_PROGRAM: seq_len = 3'h4;
         OP_CHIP, OP_BLOCK: seq_len = 3'h6;
         default: seq_len = 3'h1;
      endcase
   endfunction

   function automatic logic [27:0] seq_word(input fcpe_op_t op, input logic [2:0] idx,
                                            input logic [19:0] a, input logic [7:0] d);
      seq_word = {ADR_ANY, CD_RESET};
      case (op)
         OP_RESET: seq_word = {ADR_ANY, CD_RESET};
         OP_ADDBLK: seq_word = {a, CD_BLOCK};
         OP_SUSPEND: seq_word = {ADR_ANY, CD_SUSP};
         OP_RESUME: seq_word = {ADR_ANY, CD_RESUME};
         default: begin
            // Unlock pair before every long command
            if (idx == 3'h0 || (idx == 3'h3 && op != OP_PROGRAM)) begin
               seq_word = {ADR_UNLK1, CD_UNLK1};
            end else if (idx == 3'h1 || idx == 3'h4) begin
               seq_word = {ADR_UNLK2, CD_UNLK2};
            end else if (idx == 3'h2) begin
               seq_word = {ADR_UNLK1, (op == OP_AUTOSEL) ? CD_AUTOSEL :
                           (op == OP_PROGRAM) ? CD_PROG : CD_ERASE};
            end else if (op == OP_PROGRAM) begin
               // Fourth write carries target and value
               seq_word = {a, d};
            end else if (op == OP_CHIP) begin
               seq_word = {ADR_UNLK1, CD_CHIP};
            end else begin
               seq_word = {a, CD_BLOCK};
            end
         end
      endcase
   endfunction

   function automatic logic op_ok(input fcpe_op_t op, input logic susp);
      // While suspended only read, id, program, reset, resume
      if (susp) begin
         op_ok = op inside {OP_READ, OP_RESET, OP_AUTOSEL, OP_PROGRAM, OP_RESUME};
      end else begin
         op_ok = op inside {OP_READ, OP_RESET, OP_AUTOSEL, OP_PROGRAM, OP_CHIP, OP_BLOCK};
      end
   endfunction

   assign w0 = seq_word(cmd_op, 3'h0, cmd_addr, cmd_data);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      nxt_r = r_ff;
      nxt_r.bstart = 1'b0;
      nxt_r.rsp_v = 1'b0;
      case (r_ff.st)
         ST_IDLE, ST_WIN: begin
            if (r_ff.st == ST_WIN) begin
               nxt_r.cnt = r_ff.cnt + 32'h1;
               // No more adds close to the window end
               if (r_ff.cnt >= WIN_LEN - WIN_MARGIN_CYC) begin
                  nxt_r.rdy = 1'b0;
               end
            end
            if (r_ff.st == ST_WIN && r_ff.cnt >= WIN_LEN) begin
               nxt_r.st = ST_POLL;
               nxt_r.prev_v = 1'b0;
               nxt_r.echk = 1'b0;
               nxt_r.cnt = 32'h0;
               nxt_r.bstart = 1'b1;
               nxt_r.bwr = 1'b0;
               nxt_r.baddr = ADR_ANY;
            end else if (cmd_valid && r_ff.rdy) begin
               nxt_r.rdy = 1'b0;
               nxt_r.op = cmd_op;
               nxt_r.addr = cmd_addr;
               nxt_r.data = cmd_data;
               nxt_r.idx = 3'h0;
               if (r_ff.st == ST_WIN ? !(cmd_op inside {OP_ADDBLK, OP_SUSPEND})
                                     : !op_ok(cmd_op, r_ff.susp)) begin
                  nxt_r.rsp_v = 1'b1;
                  nxt_r.rsp_e = 1'b1;
                  nxt_r.rdy = 1'b1;
               end else begin
                  nxt_r.bstart = 1'b1;
                  nxt_r.bwr = (cmd_op != OP_READ);
                  nxt_r.baddr = (cmd_op == OP_READ) ? cmd_addr : w0[27:8];
                  nxt_r.bdat = w0[7:0];
                  nxt_r.st = (cmd_op == OP_READ) ? ST_RD : ST_WR;
               end
            end
         end
         ST_WR: begin
            if (bdone) begin
               if (r_ff.idx + 3'h1 < seq_len(r_ff.op)) begin
                  nxt_r.idx = r_ff.idx + 3'h1;
                  nxt_r.bstart = 1'b1;
                  {nxt_r.baddr, nxt_r.bdat} = seq_word(r_ff.op, r_ff.idx + 3'h1,
                                                       r_ff.addr, r_ff.data);
               end else if (r_ff.op inside {OP_BLOCK, OP_ADDBLK}) begin
                  // Window restarts with each block write
                  nxt_r.st = ST_WIN;
                  nxt_r.cnt = 32'h0;
                  nxt_r.rdy = 1'b1;
               end else if (r_ff.op inside {OP_RESET, OP_AUTOSEL}) begin
                  // Error answered only after reset went out
                  nxt_r.st = ST_IDLE;
                  nxt_r.rsp_v = 1'b1;
                  nxt_r.rsp_e = r_ff.err;
                  nxt_r.susp = r_ff.susp && !r_ff.err;
                  nxt_r.err = 1'b0;
                  nxt_r.rdy = 1'b1;
               end else begin
                  nxt_r.st = ST_POLL;
                  nxt_r.susp = r_ff.susp && (r_ff.op != OP_RESUME);
                  nxt_r.prev_v = 1'b0;
                  nxt_r.echk = 1'b0;
                  nxt_r.cnt = 32'h0;
                  nxt_r.bstart = 1'b1;
                  nxt_r.bwr = 1'b0;
                  nxt_r.baddr = (r_ff.op == OP_PROGRAM) ? r_ff.addr : ADR_ANY;
               end
            end
         end
         ST_RD: begin
            if (bdone) begin
               nxt_r.st = ST_IDLE;
               nxt_r.rsp_v = 1'b1;
               nxt_r.rsp_e = 1'b0;
               nxt_r.rsp_d = brd;
               nxt_r.rdy = 1'b1;
            end
         end
         ST_POLL: begin
            nxt_r.cnt = r_ff.cnt + 32'h1;
            if (bdone) begin
               nxt_r.prev_v = 1'b1;
               nxt_r.prev6 = brd[ALT_BUSY_POS];
               nxt_r.bstart = 1'b1;
               // Two equal toggle reads mean the controller stopped
               if (r_ff.prev_v && brd[ALT_BUSY_POS] == r_ff.prev6) begin
                  nxt_r.bstart = 1'b0;
                  nxt_r.st = ST_IDLE;
                  nxt_r.rsp_v = 1'b1;
                  nxt_r.rsp_e = 1'b0;
                  nxt_r.rsp_d = brd;
                  nxt_r.rdy = 1'b1;
                  nxt_r.susp = (r_ff.op == OP_SUSPEND) || r_ff.susp;
               end else if (r_ff.echk ||
                            r_ff.cnt >= ((r_ff.op == OP_SUSPEND) ? 32'(SUSP_CYC) : POLL_LEN)) begin
                  nxt_r.err = 1'b1;
                  nxt_r.susp = 1'b0;
                  nxt_r.op = OP_RESET;
                  nxt_r.idx = 3'h0;
                  nxt_r.st = ST_WR;
                  nxt_r.bwr = 1'b1;
                  {nxt_r.baddr, nxt_r.bdat} = {ADR_ANY, CD_RESET};
               end else if (r_ff.prev_v && brd[FAIL_POS]) begin
                  // Fail bit may race completion, so read once more
                  nxt_r.echk = 1'b1;
               end
            end
         end
         default: nxt_r.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_s) begin
      if (!rst_s) begin
         r_ff <= '{st: ST_IDLE, op: OP_READ, addr: 20'h00000, data: 8'h00, idx: 3'h0,
                   rdy: 1'b1, rsp_v: 1'b0, rsp_e: 1'b0, rsp_d: 8'h00, susp: 1'b0,
                   err: 1'b0, prev_v: 1'b0, prev6: 1'b0, echk: 1'b0, cnt: 32'h0,
                   bstart: 1'b0, bwr: 1'b0, baddr: 20'h00000, bdat: 8'h00, byte_n: 1'b0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   fcpe_bus_cycle u_bus (
      .mclk(mclk), .rst_n(rst_s), .start(r_ff.bstart), .wr(r_ff.bwr),
      .addr(r_ff.baddr), .wdata(r_ff.bdat), .done(bdone), .rdata(brd),
      .fl_addr(fl_addr), .fl_lsb(shared_top_data_low_addr_pin_o),
      .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i),
      .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n)
   );

   assign cmd_ready = r_ff.rdy;
   assign rsp_valid = r_ff.rsp_v;
   assign rsp_err = r_ff.rsp_e;
   assign rsp_data = r_ff.rsp_d;
   assign erase_suspended = r_ff.susp;
   // Byte mode: shared pin driven as low address once synchronised reset is released
   assign fl_byte_n = r_ff.byte_n;
   assign shared_top_data_low_addr_pin_oe = rst_s;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_long_start;
      r_ff.bstart && r_ff.bwr && r_ff.idx == 3'h0 && seq_len(r_ff.op) > 3'h1;
   endsequence
   a_unlock_first: assert property (@(posedge mclk) disable iff (!rst_s)
      s_long_start |-> r_ff.baddr == ADR_UNLK1 && r_ff.bdat == CD_UNLK1)
      else $error("first unlock word wrong");
   a_unlock_second: assert property (@(posedge mclk) disable iff (!rst_s)
      r_ff.bstart && r_ff.bwr && r_ff.idx == 3'h1 |-> r_ff.baddr == ADR_UNLK2 &&
      r_ff.bdat == CD_UNLK2) else $error("second unlock word wrong");
   a_prog_value: assert property (@(posedge mclk) disable iff (!rst_s)
      r_ff.bstart && r_ff.op == OP_PROGRAM && r_ff.idx == 3'h3 |->
      r_ff.baddr == r_ff.addr && r_ff.bdat == r_ff.data) else $error("program word wrong");
   a_chip_confirm: assert property (@(posedge mclk) disable iff (!rst_s)
      r_ff.bstart && r_ff.op == OP_CHIP && r_ff.idx == 3'h5 |-> r_ff.bdat == CD_CHIP)
      else $error("chip erase confirm wrong");
   a_err_reset: assert property (@(posedge mclk) disable iff (!rst_s)
      $rose(r_ff.err) |-> r_ff.bstart && r_ff.bdat == CD_RESET)
      else $error("failure not followed by reset write");
   a_win_bound: assert property (@(posedge mclk) disable iff (!rst_s)
      r_ff.st == ST_WIN |-> r_ff.cnt <= WIN_LEN) else $error("block window overran");
   a_rsp_pulse: assert property (@(posedge mclk) disable iff (!rst_s)
      rsp_valid |=> !rsp_valid) else $error("answer longer than one cycle");
   a_auto_third: assert property (@(posedge mclk) disable iff (!rst_s)
      r_ff.bstart && r_ff.op == OP_AUTOSEL && r_ff.idx == 3'h2 |->
      r_ff.bdat == CD_AUTOSEL && r_ff.baddr == ADR_UNLK1) else $error("id word wrong");
endmodule // fcpe_ctrl
